/* File: adcs_pkg.sv */
// package of constants and types for the conversion sequencer
// Functional notes
// - start bit begins conversion of selected channel
// - completion loads result, sets done, pulses interrupt
// - start bit clears itself once conversion begins
// - result only after selected conversion time
// - reading result clears done flag
// - restart clears done, old result kept
// - each conversion yields 8-bit unsigned code
// - halt or low-speed aborts, resets both controls
// - halt or low-speed entry loses earlier results
// - no automatic restart after halt or low-speed
// - ladder disconnected in halt or low-speed
// - channel codes zero to five valid, rest reserved
// - time codes give 39 to 1248 clocks
// - busy set at start, cleared at end/abort
// - controls held at reset, writes ignored in halt
`default_nettype none

package adcs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADCS_CTL_ONE_ADDR = 8'h0E;
  localparam logic [7:0] ADCS_CTL_TWO_ADDR = 8'h0F;
  localparam logic [7:0] ADCS_STATUS_ADDR  = 8'h26;
  localparam logic [7:0] ADCS_RESULT_ADDR  = 8'h27;

  // ==========================================================
  // field positions
  localparam int ADCS_START_POS     = 7;
  localparam int ADCS_AIN_DIS_POS   = 4;
  localparam int ADCS_LADDER_POS    = 5;
  localparam int ADCS_DONE_POS      = 5;
  localparam int ADCS_BUSY_POS      = 4;
  localparam int ADCS_LAST_CHANNEL  = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0] ADCS_CTL_ONE_RST = 8'h30;
  localparam logic [7:0] ADCS_CTL_TWO_RST = 8'h10;
  localparam logic [7:0] ADCS_RESULT_RST  = 8'h00;

  // ==========================================================
  // conversion lengths in system clock periods
  localparam int ADCS_T39_CLK   = 39;
  localparam int ADCS_T78_CLK   = 78;
  localparam int ADCS_T156_CLK  = 156;
  localparam int ADCS_T312_CLK  = 312;
  localparam int ADCS_T624_CLK  = 624;
  localparam int ADCS_T1248_CLK = 1248;
  localparam int ADCS_CNT_W     = 11;
  localparam int ADCS_SAR_STEPS = 8;

  typedef struct packed {
    logic       start;       // conv_start_bit
    logic [1:0] fixed_hi;    // 0 then 1 at reset, not forced on write
    logic       ain_dis;     // analog_input_disable
    logic [3:0] chan;        // channel_select
  } adcs_ctl_one_s;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic       ladder;      // ladder_connect_ctrl
    logic       fixed_one;
    logic [2:0] tsel;
    logic       fixed_zero;
  } adcs_ctl_two_s;

  typedef enum logic [1:0] {ADCS_IDLE, ADCS_CONV} adcs_state_e;

endpackage

`default_nettype wire

/* File: adcs_conv_timer.sv */
// conversion-time counter with terminal detect
`timescale 1ns/1ps
`default_nettype none

module adcs_conv_timer
  import adcs_pkg::*;
(
  input  wire logic                  core_clk,  // system clock
  input  wire logic                  arst_n,    // async reset
  input  wire logic                  clk_en,    // freezes state when low
  input  wire logic                  run,       // count while high
  input  wire logic [ADCS_CNT_W-1:0] term,      // length in clocks
  output logic      [ADCS_CNT_W-1:0] count,     // clocks since start
  output logic                       last       // final clock of run
);

  logic [ADCS_CNT_W-1:0] cnt_q;
  logic [ADCS_CNT_W-1:0] cnt_d;

  assign count = cnt_q;
  assign last  = run && (cnt_q == term - 11'h001);

  always_comb
  begin
    cnt_d = cnt_q;
    if (!run || last)
      cnt_d = '0;
    else
      cnt_d = cnt_q + 11'h001;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= '0;
    else if (clk_en)
      cnt_q <= cnt_d;
  end

endmodule // adcs_conv_timer

`default_nettype wire

/* File: adcs_sequencer.sv */
// successive-approximation conversion sequencer with register port
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer
  import adcs_pkg::*;
(
  input  wire logic       core_clk,       // system clock, 10 MHz
  input  wire logic       arst_n,         // async reset, active low
  input  wire logic       clk_en,         // freezes all state when low
  input  wire logic       low_power_mode, // halt or low-speed mode active
  input  wire logic [7:0] addr,           // register address
  input  wire logic [7:0] wr_data,        // register write data
  input  wire logic       wr_en,          // write strobe
  input  wire logic       rd_en,          // read strobe
  input  wire logic       cmp_in,         // comparator: input >= trial code
  output logic      [7:0] rd_data,        // read data, cycle after strobe
  output logic      [7:0] dac_code,       // trial code to the ladder
  output logic      [3:0] mux_sel,        // analog channel to sample
  output logic            mux_en,         // analog input enabled
  output logic            ladder_on,      // reference ladder connected
  output logic            conv_done_irq   // one-clock completion pulse
);

  // ==========================================================
  // state
  adcs_ctl_one_s         one_q, one_d;
  adcs_ctl_two_s         two_q, two_d;
  adcs_state_e           st_q, st_d;
  logic [7:0]            res_q, res_d;
  logic [7:0]            sar_q, sar_d;
  logic                  done_q, done_d;
  logic                  irq_q, irq_d;
  logic [7:0]            rdat_q, rdat_d;
  logic [3:0]            mux_q, mux_d;
  logic                  men_q, men_d;
  logic                  lad_q, lad_d;
  logic [ADCS_CNT_W-1:0] term;
  logic [ADCS_CNT_W-1:0] count;
  logic                  last;
  logic                  busy;
  logic                  begin_conv;
  logic [2:0]            bit_idx;

  assign busy       = (st_q == ADCS_CONV);
  assign begin_conv = one_q.start && !busy && !low_power_mode;
  assign bit_idx    = 3'h7 - count[2:0];

  // ==========================================================
  // conversion length select
  always_comb
  begin
    unique case (two_q.tsel)
      3'h2:    term = ADCS_CNT_W'(ADCS_T78_CLK);
      3'h3:    term = ADCS_CNT_W'(ADCS_T156_CLK);
      3'h4:    term = ADCS_CNT_W'(ADCS_T312_CLK);
      3'h5:    term = ADCS_CNT_W'(ADCS_T624_CLK);
      3'h6:    term = ADCS_CNT_W'(ADCS_T1248_CLK);
      // reserved codes fall back to the shortest length
      default: term = ADCS_CNT_W'(ADCS_T39_CLK);
    endcase
  end

  adcs_conv_timer u_timer (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .run      (busy && !low_power_mode),
    .term     (term),
    .count    (count),
    .last     (last)
  );

  // ==========================================================
  // control registers
  always_comb
  begin
    one_d = one_q;
    two_d = two_q;
    if (low_power_mode)
    begin
      one_d = adcs_ctl_one_s'(ADCS_CTL_ONE_RST);
      two_d = adcs_ctl_two_s'(ADCS_CTL_TWO_RST);
    end
    else
    begin
      if (begin_conv)
        one_d.start = 1'b0;
      if (wr_en && addr == ADCS_CTL_ONE_ADDR)
      begin
        one_d = adcs_ctl_one_s'(wr_data);
        // a start written while busy or on the accept edge is dropped, not queued,
        // otherwise it would survive the self-clear and restart on its own
        if (busy || begin_conv)
          one_d.start = 1'b0;
      end
      if (wr_en && addr == ADCS_CTL_TWO_ADDR)
      begin
        two_d = adcs_ctl_two_s'(wr_data);
        two_d.unused_hi = 2'h0;
      end
    end
  end

  // ==========================================================
  // sequencer, approximation and result
  always_comb
  begin
    st_d   = st_q;
    sar_d  = sar_q;
    res_d  = res_q;
    done_d = done_q;
    irq_d  = 1'b0;
    if (rd_en && addr == ADCS_RESULT_ADDR)
      done_d = 1'b0;
    if (low_power_mode)
    begin
      st_d   = ADCS_IDLE;
      sar_d  = 8'h00;
      res_d  = ADCS_RESULT_RST;
      done_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        ADCS_IDLE:
        begin
          if (begin_conv)
          begin
            st_d   = ADCS_CONV;
            sar_d  = 8'h80;
            done_d = 1'b0;
          end
        end
        ADCS_CONV:
        begin
          if (count < ADCS_CNT_W'(ADCS_SAR_STEPS))
          begin
            if (!cmp_in)
              sar_d[bit_idx] = 1'b0;
            if (bit_idx != 3'h0)
              sar_d[bit_idx - 3'h1] = 1'b1;
          end
          if (last)
          begin
            st_d   = ADCS_IDLE;
            res_d  = sar_q;
            done_d = 1'b1; // set wins over a same-cycle read
            irq_d  = 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // read port and analog-side outputs
  always_comb
  begin
    rdat_d = 8'h00;
    if (rd_en)
    begin
      unique case (addr)
        ADCS_CTL_ONE_ADDR: rdat_d = one_q;
        ADCS_CTL_TWO_ADDR: rdat_d = two_q;
        ADCS_STATUS_ADDR:
        begin
          rdat_d[ADCS_DONE_POS] = done_q;
          rdat_d[ADCS_BUSY_POS] = busy;
        end
        ADCS_RESULT_ADDR:  rdat_d = res_q;
        default:           rdat_d = 8'h00;
      endcase
    end
    mux_d = one_q.chan;
    men_d = !one_q.ain_dis && one_q.chan <= 4'(ADCS_LAST_CHANNEL) && !low_power_mode;
    // ladder follows the mode bit or the conversion, and halt always wins
    lad_d = !low_power_mode && (two_q.ladder || busy || begin_conv);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      one_q  <= adcs_ctl_one_s'(ADCS_CTL_ONE_RST);
      two_q  <= adcs_ctl_two_s'(ADCS_CTL_TWO_RST);
      st_q   <= ADCS_IDLE;
      sar_q  <= 8'h00;
      res_q  <= ADCS_RESULT_RST;
      done_q <= 1'b0;
      irq_q  <= 1'b0;
      rdat_q <= 8'h00;
      mux_q  <= 4'h0;
      men_q  <= 1'b0;
      lad_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      one_q  <= one_d;
      two_q  <= two_d;
      st_q   <= st_d;
      sar_q  <= sar_d;
      res_q  <= res_d;
      done_q <= done_d;
      irq_q  <= irq_d;
      rdat_q <= rdat_d;
      mux_q  <= mux_d;
      men_q  <= men_d;
      lad_q  <= lad_d;
    end
  end

  assign rd_data       = rdat_q;
  assign dac_code      = sar_q;
  assign mux_sel       = mux_q;
  assign mux_en        = men_q;
  assign ladder_on     = lad_q;
  assign conv_done_irq = irq_q;

endmodule // adcs_sequencer

`default_nettype wire

/* File: adcs_sequencer_sva.sv */
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer_sva
  import adcs_pkg::*;
(
  input wire logic       core_clk,       // system clock
  input wire logic       arst_n,         // async reset
  input wire logic       low_power_mode, // halt or low-speed
  input wire logic [7:0] addr,           // register address
  input wire logic [7:0] wr_data,        // write data
  input wire logic       wr_en,          // write strobe
  input wire logic       rd_en,          // read strobe
  input wire logic [7:0] rd_data,        // read data
  input wire logic [7:0] dac_code,       // trial code
  input wire logic       mux_en,         // input enabled
  input wire logic       ladder_on,      // ladder connected
  input wire logic       conv_done_irq   // completion pulse
);
  wire logic rd_st = rd_en && addr == ADCS_STATUS_ADDR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ========
  // checks
  irq_one_clk_a: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("irq pulse longer than one clock");
  rd_idle_zero_a: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not zero without strobe");
  done_with_irq_a: assert property (conv_done_irq && rd_st |=> rd_data == 8'h20)
    else $error("done not set with irq");
  rd_clears_done_a: assert property ((rd_en && addr == ADCS_RESULT_ADDR) ##1
    (rd_st && !conv_done_irq) |=> !rd_data[ADCS_DONE_POS]) else $error("done kept after read");
  lp_status_clr_a: assert property (low_power_mode && $past(low_power_mode) && rd_st
    |=> rd_data == 8'h00) else $error("status not cleared in low power");
  lp_ctl_reset_a: assert property (low_power_mode && $past(low_power_mode) && rd_en
    && addr == ADCS_CTL_ONE_ADDR |=> rd_data == ADCS_CTL_ONE_RST) else $error("control kept");
  lp_ladder_off_a: assert property (low_power_mode ##1 low_power_mode
    |-> !ladder_on && !mux_en) else $error("ladder on in low power");
  start_dac_a: assert property ((wr_en && addr == ADCS_CTL_ONE_ADDR
    && wr_data[ADCS_START_POS] && !low_power_mode) ##1 !low_power_mode
    |=> dac_code == 8'h80 && ladder_on) else $error("start did not begin conversion");
  cover property (conv_done_irq && rd_st);
  cover property ((rd_en && addr == ADCS_RESULT_ADDR) ##1 rd_st);
  cover property ($rose(low_power_mode));
endmodule // adcs_sequencer_sva
`default_nettype wire

/* File: adcs_analog_model.sv */
// analog inputs and comparator seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model
  import adcs_pkg::*;
(
  input  wire logic       core_clk, // system clock
  input  wire logic [7:0] dac_code, // trial code
  input  wire logic [3:0] mux_sel,  // selected channel
  input  wire logic       mux_en,   // input path enabled
  output logic            cmp_in    // input at or above trial code
);
  logic       noise_q = 1'b0;
  logic [7:0] level;
  // a cut-off input toggles so a stale level never looks valid
  always_ff @(posedge core_clk) noise_q <= !noise_q;
  assign level  = {mux_sel[2:0], 5'h0B};
  assign cmp_in = mux_en ? (level >= dac_code) : noise_q;
endmodule // adcs_analog_model
`default_nettype wire

/* File: adcs_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer_tb
  import adcs_pkg::*;
;
  logic       core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, low_power_mode = 1'b0;
  logic       wr_en = 1'b0, rd_en = 1'b0, cmp_in, mux_en, ladder_on, conv_done_irq;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, dac_code, old_q = 8'h00;
  logic [3:0] mux_sel;
  bit         old_ok = 1'b1;
  int         num_errors = 0, samples_checked = 0;
  always #50 core_clk = !core_clk;
  adcs_sequencer i_dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .low_power_mode(low_power_mode), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .cmp_in(cmp_in), .rd_data(rd_data), .dac_code(dac_code),
    .mux_sel(mux_sel), .mux_en(mux_en), .ladder_on(ladder_on), .conv_done_irq(conv_done_irq));
  adcs_analog_model i_far (.core_clk(core_clk), .dac_code(dac_code), .mux_sel(mux_sel),
    .mux_en(mux_en), .cmp_in(cmp_in));
  // ========
  // bus and compare helpers; tasks start and end at a rising edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr_en   <= w;
    rd_en   <= !w;
    addr    <= a;
    wr_data <= d;
    @(posedge core_clk);
  endtask
  task automatic quiet;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    put(1'b0, a, 8'h00);
    quiet();
    chk(rd_data, exp, what);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ========
  // scenarios
  task automatic t_reset_regs;
    rd(ADCS_CTL_ONE_ADDR, ADCS_CTL_ONE_RST, "ctl one reset");
    rd(ADCS_CTL_TWO_ADDR, ADCS_CTL_TWO_RST, "ctl two reset");
    rd(ADCS_STATUS_ADDR, 8'h00, "status reset");
    rd(ADCS_RESULT_ADDR, ADCS_RESULT_RST, "result reset");
    rd(8'h55, 8'h00, "unmapped read");
    $display("test reset_regs done");
  endtask
  // status is polled every cycle after the first result read, so the read beside the irq pulse is seen too
  task automatic t_run(input logic [3:0] ch, input logic [2:0] tc, input int n, input bit rb);
    int k;
    put(1'b1, ADCS_CTL_TWO_ADDR, {4'h1, tc, 1'b0});
    put(1'b1, ADCS_CTL_ONE_ADDR, {4'h2, ch});
    put(1'b1, ADCS_CTL_ONE_ADDR, {4'hA, ch});
    for (k = 1; k < 1400; k++)
    begin
      put(1'b0, (k == 1) ? ADCS_RESULT_ADDR : ADCS_STATUS_ADDR, 8'h00);
      if (k == 2 && old_ok)
        chk(rd_data, old_q, "old result kept");
      if (k == 3)
      begin
        chk(rd_data, 8'h10, "busy with done clear");
        chk({mux_en, ladder_on, 2'b00, mux_sel},
            {ch <= 4'd5, 3'b100, ch}, "input path");
      end
      if (k == n + 2)
        chk(rd_data, 8'h10, "still busy before end");
      if (conv_done_irq === 1'b1)
        break;
    end
    if (k >= 1400)
    begin
      num_errors++;
      $display("[ERR] %0t no completion", $time);
      wrap_up();
    end
    chk(16'(k), 16'(n + 2), "conversion length");
    quiet();
    chk(rd_data, 8'h20, "done set");
    rd(ADCS_CTL_ONE_ADDR, {4'h2, ch}, "start self-cleared");
    if (rb)
    begin
      put(1'b0, ADCS_RESULT_ADDR, 8'h00);
      put(1'b0, ADCS_STATUS_ADDR, 8'h00);
      if (ch <= 4'd5)
        chk(rd_data, {ch[2:0], 5'h0B}, "result code");
      quiet();
      chk(rd_data, 8'h00, "done cleared by read");
    end
    old_ok = (ch <= 4'd5);
    old_q  = {ch[2:0], 5'h0B};
    $display("test run done");
  endtask
  // enable dropped mid-conversion: counter and trial code must hold; reserved time code 7
  task automatic t_freeze;
    int k;
    put(1'b1, ADCS_CTL_TWO_ADDR, 8'h1E);
    put(1'b1, ADCS_CTL_ONE_ADDR, 8'h21);
    put(1'b1, ADCS_CTL_ONE_ADDR, 8'hA1);
    quiet();
    clk_en <= 1'b0;
    repeat (10) quiet();
    chk({dac_code, 7'h00, conv_done_irq}, {8'h80, 8'h00}, "frozen state");
    clk_en <= 1'b1;
    for (k = 1; k < 100; k++)
    begin
      quiet();
      if (conv_done_irq === 1'b1)
        break;
    end
    // the pulse is seen one edge after it is launched
    chk(16'(k), 16'(ADCS_T39_CLK + 1), "frozen length");
    rd(ADCS_RESULT_ADDR, 8'h2B, "frozen result");
    rd(ADCS_STATUS_ADDR, 8'h00, "frozen done cleared");
    $display("test freeze done");
  endtask
  task automatic t_low_power;
    int k;
    put(1'b1, ADCS_CTL_TWO_ADDR, 8'h3C);
    put(1'b1, ADCS_CTL_ONE_ADDR, 8'hB2);
    repeat (10) quiet();
    chk({mux_en, ladder_on}, 2'b01, "input disabled");
    low_power_mode <= 1'b1;
    quiet();
    quiet();
    put(1'b1, ADCS_CTL_ONE_ADDR, 8'hA1);
    rd(ADCS_CTL_ONE_ADDR, ADCS_CTL_ONE_RST, "ctl one held");
    rd(ADCS_CTL_TWO_ADDR, ADCS_CTL_TWO_RST, "ctl two reset");
    rd(ADCS_STATUS_ADDR, 8'h00, "busy cleared");
    rd(ADCS_RESULT_ADDR, 8'h00, "result dropped");
    chk(ladder_on, 1'b0, "ladder cut");
    low_power_mode <= 1'b0;
    for (k = 0; k < 1300; k++)
    begin
      quiet();
      chk({conv_done_irq, ladder_on}, 2'b00, "no restart");
    end
    old_q = 8'h00;
    old_ok = 1'b1;
    $display("test low_power done");
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset_regs();
    t_run(4'd3, 3'd0, ADCS_T39_CLK, 1'b1);
    t_run(4'd0, 3'd2, ADCS_T78_CLK, 1'b0);
    t_run(4'd5, 3'd3, ADCS_T156_CLK, 1'b1);
    t_run(4'd1, 3'd4, ADCS_T312_CLK, 1'b1);
    t_run(4'd2, 3'd5, ADCS_T624_CLK, 1'b1);
    t_run(4'd4, 3'd6, ADCS_T1248_CLK, 1'b1);
    t_run(4'd6, 3'd1, ADCS_T39_CLK, 1'b1);
    t_freeze();
    t_low_power();
    t_run(4'd5, 3'd0, ADCS_T39_CLK, 1'b1);
    wrap_up();
  end
endmodule // adcs_sequencer_tb
bind adcs_sequencer adcs_sequencer_sva i_sva (.core_clk(core_clk), .arst_n(arst_n),
  .low_power_mode(low_power_mode), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .dac_code(dac_code), .mux_en(mux_en),
  .ladder_on(ladder_on), .conv_done_irq(conv_done_irq));
`default_nettype wire
